// file: dlic_top.sv
`default_nettype none
// Function
// - OR of normal status drives normal request
// - Raw normal bits follow peripheral requests, read-only
// - Mask one enables source, zero masks it
// - Enable mask writes only set bits
// - Write-only clear register clears mask ones
// - Masked status bits 31..1 equal raw AND mask
// - No priority encoder, no vector
// - Fast level mirrors normal register set
// - Fast status bits 31..1 ORed, feed bit 0
// - Fast enable write clears matching normal bit
// - Normal enable write clears matching fast bit
// - Source may be masked on both levels
// - Programmed interrupts bypass the masks
// - Software bit 2 drives fast bit 1
// - Software bit 1 drives normal bit 1
module dlic_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Peripheral requests
  input wire logic [31:0] normal_req_in,
  input wire logic [31:0] fast_req_in,
  // AXI4-Lite write address
  input wire logic [5:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [5:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core requests
  output logic normal_interrupt_request,
  output logic fast_interrupt_request
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte-lane merge of write data onto a zero word
  function automatic logic [31:0] lane_data(input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = dlic_pkg::DLIC_ZERO;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Lane-wise select of new data over old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Word-aligned register offset; byte address bits 1:0 are ignored
  function automatic logic [5:0] word_offset(input logic [5:0] a);
    return {a[5:2], 2'b00};
  endfunction

  // Enable bits set by the ones of a written word
  function automatic logic [31:0] set_bits(input logic [31:0] old, input logic [31:0] ones);
    return old | ones;
  endfunction

  // Enable bits cleared by the ones of a written word
  function automatic logic [31:0] clear_bits(input logic [31:0] old, input logic [31:0] ones);
    return old & ~ones;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] normal_enable_mask_reg;
  logic [31:0] fast_enable_mask_reg;
  logic [31:0] software_interrupt_control_reg;
  logic [31:0] normal_raw_source;
  logic [31:0] normal_masked_status;
  logic [31:0] fast_raw_source;
  logic [31:0] fast_masked_status;
  logic fast_or;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [5:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [31:0] wr_bits;
  logic wr_hit;

  // Address and data accepted in either order, one write in flight
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_bits = lane_data(w_data_reg, w_strb_reg);

  // Write address capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Decode of writable offsets
  always_comb begin
    unique case (word_offset(aw_addr_reg))
      dlic_pkg::DLIC_OFF_NORMAL_ENABLE_MASK,
      dlic_pkg::DLIC_OFF_NORMAL_ENABLE_CLEAR,
      dlic_pkg::DLIC_OFF_FAST_ENABLE_MASK,
      dlic_pkg::DLIC_OFF_FAST_ENABLE_CLEAR,
      dlic_pkg::DLIC_OFF_SOFTWARE_INTERRUPT_CONTROL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response valid, held until bready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Write response code; read-only or unmapped offsets answer SLVERR
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bresp <= dlic_pkg::DLIC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_hit ? dlic_pkg::DLIC_RESP_OKAY : dlic_pkg::DLIC_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Enable masks
  // ----------------------------------------------------------------
  logic wr_normal_en;
  logic wr_normal_clr;
  logic wr_fast_en;
  logic wr_fast_clr;
  logic wr_swi;
  logic [5:0] wr_off;

  assign wr_off = word_offset(aw_addr_reg);
  assign wr_normal_en = wr_fire && (wr_off == dlic_pkg::DLIC_OFF_NORMAL_ENABLE_MASK);
  assign wr_normal_clr = wr_fire && (wr_off == dlic_pkg::DLIC_OFF_NORMAL_ENABLE_CLEAR);
  assign wr_fast_en = wr_fire && (wr_off == dlic_pkg::DLIC_OFF_FAST_ENABLE_MASK);
  assign wr_fast_clr = wr_fire && (wr_off == dlic_pkg::DLIC_OFF_FAST_ENABLE_CLEAR);
  assign wr_swi = wr_fire && (wr_off == dlic_pkg::DLIC_OFF_SOFTWARE_INTERRUPT_CONTROL);

  // Normal mask: set by ones, cleared by clear reg or fast enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      normal_enable_mask_reg <= dlic_pkg::DLIC_ZERO;
    end else if (wr_normal_en) begin
      normal_enable_mask_reg <= set_bits(normal_enable_mask_reg, wr_bits);
    end else if (wr_normal_clr) begin
      normal_enable_mask_reg <= clear_bits(normal_enable_mask_reg, wr_bits);
    end else if (wr_fast_en) begin
      normal_enable_mask_reg <= clear_bits(normal_enable_mask_reg, wr_bits);
    end
  end

  // Fast mask: same scheme, cleared by normal enable writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_enable_mask_reg <= dlic_pkg::DLIC_ZERO;
    end else if (wr_fast_en) begin
      fast_enable_mask_reg <= set_bits(fast_enable_mask_reg, wr_bits);
    end else if (wr_fast_clr) begin
      fast_enable_mask_reg <= clear_bits(fast_enable_mask_reg, wr_bits);
    end else if (wr_normal_en) begin
      fast_enable_mask_reg <= clear_bits(fast_enable_mask_reg, wr_bits);
    end
  end

  // Software interrupt register; reserved bits held at zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      software_interrupt_control_reg <= dlic_pkg::DLIC_ZERO;
    end else if (wr_swi) begin
      software_interrupt_control_reg <=
        lane_merge(software_interrupt_control_reg, w_data_reg, w_strb_reg)
        & dlic_pkg::DLIC_SWI_IMPL_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt levels
  // ----------------------------------------------------------------
  // Fast level: bit 0 slot carries the fast OR itself
  dlic_level u_fast (
    .periph_req(fast_req_in),
    .fast_or(fast_or),
    .soft_req(software_interrupt_control_reg[dlic_pkg::DLIC_SWI_FAST_BIT]),
    .enable_mask(fast_enable_mask_reg),
    .raw_source(fast_raw_source),
    .masked_status(fast_masked_status)
  );

  // Normal level
  dlic_level u_normal (
    .periph_req(normal_req_in),
    .fast_or(fast_or),
    .soft_req(software_interrupt_control_reg[dlic_pkg::DLIC_SWI_NORMAL_BIT]),
    .enable_mask(normal_enable_mask_reg),
    .raw_source(normal_raw_source),
    .masked_status(normal_masked_status)
  );

  // Enabled fast pin requests above the OR slot
  logic [31:1] fast_hits;
  assign fast_hits = fast_req_in[31:1] & fast_enable_mask_reg[31:1];

  // Fast OR of status bits 31..1 built from inputs, so bit 0 never feeds itself
  assign fast_or = |fast_hits
                   | software_interrupt_control_reg[dlic_pkg::DLIC_SWI_FAST_BIT];

  // Normal core request; no vector or priority encoding
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      normal_interrupt_request <= 1'b0;
    end else begin
      normal_interrupt_request <= |normal_masked_status;
    end
  end

  // Fast core request from the fast OR
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_interrupt_request <= 1'b0;
    end else begin
      fast_interrupt_request <= fast_or;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic rd_hit;
  logic [5:0] rd_off;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_off = word_offset(s_axi_araddr);

  // Read decode; clear registers are write-only and read as zero
  always_comb begin
    rd_hit = 1'b1;
    unique case (rd_off)
      dlic_pkg::DLIC_OFF_NORMAL_RAW_SOURCE: rd_word = normal_raw_source;
      dlic_pkg::DLIC_OFF_NORMAL_ENABLE_MASK: rd_word = normal_enable_mask_reg;
      dlic_pkg::DLIC_OFF_NORMAL_ENABLE_CLEAR: rd_word = dlic_pkg::DLIC_ZERO;
      dlic_pkg::DLIC_OFF_NORMAL_MASKED_STATUS: rd_word = normal_masked_status;
      dlic_pkg::DLIC_OFF_FAST_RAW_SOURCE: rd_word = fast_raw_source;
      dlic_pkg::DLIC_OFF_FAST_ENABLE_MASK: rd_word = fast_enable_mask_reg;
      dlic_pkg::DLIC_OFF_FAST_ENABLE_CLEAR: rd_word = dlic_pkg::DLIC_ZERO;
      dlic_pkg::DLIC_OFF_FAST_MASKED_STATUS: rd_word = fast_masked_status;
      dlic_pkg::DLIC_OFF_SOFTWARE_INTERRUPT_CONTROL: rd_word = software_interrupt_control_reg;
      default: begin
        rd_word = dlic_pkg::DLIC_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read valid: raised on a taken address, dropped on rready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Read data and response, held until taken
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_rdata <= dlic_pkg::DLIC_ZERO;
      s_axi_rresp <= dlic_pkg::DLIC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? dlic_pkg::DLIC_RESP_OKAY : dlic_pkg::DLIC_RESP_SLVERR;
    end
  end

  // Protection fields carry no meaning here
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot, aw_addr_reg[1:0], s_axi_araddr[1:0]};
endmodule
`default_nettype wire

// file: dlic_pkg.sv
`default_nettype none
package dlic_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] DLIC_OFF_NORMAL_RAW_SOURCE = 6'h00;
  localparam logic [5:0] DLIC_OFF_NORMAL_ENABLE_MASK = 6'h04;
  localparam logic [5:0] DLIC_OFF_NORMAL_ENABLE_CLEAR = 6'h08;
  localparam logic [5:0] DLIC_OFF_NORMAL_MASKED_STATUS = 6'h0C;
  localparam logic [5:0] DLIC_OFF_FAST_RAW_SOURCE = 6'h10;
  localparam logic [5:0] DLIC_OFF_FAST_ENABLE_MASK = 6'h14;
  localparam logic [5:0] DLIC_OFF_FAST_ENABLE_CLEAR = 6'h18;
  localparam logic [5:0] DLIC_OFF_FAST_MASKED_STATUS = 6'h1C;
  localparam logic [5:0] DLIC_OFF_SOFTWARE_INTERRUPT_CONTROL = 6'h20;

  // ----------------------------------------------------------------
  // Widths, field positions, reset values
  // ----------------------------------------------------------------
  localparam int DLIC_WIDTH = 32;
  localparam int DLIC_ADDR_W = 6;
  localparam int DLIC_FAST_SRC_BIT = 0;
  localparam int DLIC_SOFT_SRC_BIT = 1;
  localparam int DLIC_SWI_NORMAL_BIT = 1;
  localparam int DLIC_SWI_FAST_BIT = 2;
  localparam logic [31:0] DLIC_SWI_IMPL_MASK = 32'h0000_0006;
  localparam logic [31:0] DLIC_ZERO = 32'h0000_0000;
  localparam logic [1:0] DLIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DLIC_RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// file: dlic_level.sv
`default_nettype none
// ------------------------------------------------------------------
// One interrupt level: raw source merge and masked status
// ------------------------------------------------------------------
module dlic_level (
  // Inputs
  input wire logic [31:0] periph_req,
  input wire logic fast_or,
  input wire logic soft_req,
  input wire logic [31:0] enable_mask,
  // Outputs
  output logic [31:0] raw_source,
  output logic [31:0] masked_status
);
  // Raw sources follow requesters, bit 0 from fast OR, bit 1 from its request line OR software
  always_comb begin
    raw_source = periph_req;
    raw_source[dlic_pkg::DLIC_FAST_SRC_BIT] = fast_or;
    raw_source[dlic_pkg::DLIC_SOFT_SRC_BIT] = periph_req[dlic_pkg::DLIC_SOFT_SRC_BIT] | soft_req;
  end

  // Masked status bits 31..1 are raw AND mask, bit 0 is the fast OR; programmed requests bypass the mask
  always_comb begin
    masked_status = raw_source & enable_mask;
    masked_status[dlic_pkg::DLIC_FAST_SRC_BIT] = fast_or;
    if (soft_req) begin
      masked_status[dlic_pkg::DLIC_SOFT_SRC_BIT] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: dlic_periph_model.sv
`default_nettype none
// ----------------------------------------
// Peripheral request sources
// ----------------------------------------
module dlic_periph_model #(
  parameter int MIN_HOLD = 4
) (
  // Clock
  input wire logic sys_clk,
  // Wanted request patterns
  input wire logic [31:0] normal_set,
  input wire logic [31:0] fast_set,
  // Request lines
  output var logic [31:0] normal_req_in,
  output var logic [31:0] fast_req_in
);
  int hold;
  // Quiet lines at start, then each new pattern stays up MIN_HOLD cycles at least
  initial begin
    normal_req_in = 32'h0;
    fast_req_in = 32'h0;
    hold = 0;
    forever begin
      @(posedge sys_clk);
      if (hold > 0) begin
        hold <= hold - 1;
      end else if ({normal_set, fast_set} !== {normal_req_in, fast_req_in}) begin
        normal_req_in <= normal_set;
        fast_req_in <= fast_set;
        hold <= MIN_HOLD;
      end
    end
  end
endmodule
`default_nettype wire

// file: dlic_properties.sv
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module dlic_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core requests
  input wire logic normal_interrupt_request,
  input wire logic fast_interrupt_request
);
  logic wr_seen_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Any write address taken since reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_seen_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_seen_reg <= 1'b1;
    end
  end
  property p_rst_quiet;
    $fell(rst) |-> !normal_interrupt_request && !fast_interrupt_request && !s_axi_bvalid;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_quiet_until_write;
    !wr_seen_reg |-> !normal_interrupt_request && !fast_interrupt_request;
  endproperty
  a_quiet_until_write: assert property (p_quiet_until_write) else $error("request unmasked");
  property p_fast_to_normal;
    fast_interrupt_request |-> normal_interrupt_request;
  endproperty
  a_fast_to_normal: assert property (p_fast_to_normal) else $error("fast not on normal bit");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write response late");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read data late");
  property p_ar_gate;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_gate: assert property (p_ar_gate) else $error("read address taken while busy");
endmodule
bind dlic_top dlic_checker u_chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .normal_interrupt_request, .fast_interrupt_request);
`default_nettype wire

// file: dual_level_interrupt_controller_test.sv
`default_nettype none
module dual_level_interrupt_controller_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [31:0] data;
    logic [1:0] resp;
    logic [1:0] irq;
  } dlic_row_t;
  logic sys_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, normal_interrupt_request, fast_interrupt_request;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, normal_set, fast_set, normal_req_in, fast_req_in, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int err_count, n_compared;
  dlic_row_t rows [29];
  // ----------------------------------------
  // Design and request sources
  // ----------------------------------------
  dlic_top uut (.sys_clk, .rst, .normal_req_in, .fast_req_in, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .normal_interrupt_request,
    .fast_interrupt_request);
  dlic_periph_model u_src (.sys_clk, .normal_set, .fast_set, .normal_req_in, .fast_req_in);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access, held until each channel is taken
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    logic aw, w;
    aw = wr;
    w = wr;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    forever begin
      @(posedge sys_clk);
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
      if (!wr && s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (wr && s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (!wr && s_axi_rvalid) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    // Let an edge pass so a following call never re-drives a strobe at once
    @(posedge sys_clk);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // About 230 cycles of work expected
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    $display("watchdog expired");
    complete_run();
  end
  // Access table: wr, offset, data, response, {normal, fast}
  initial begin
    rows = '{
      '{1'b0, 6'h04, 32'h0, 2'h0, 2'h0}, '{1'b0, 6'h20, 32'h0, 2'h0, 2'h0},
      '{1'b0, 6'h00, 32'hF00, 2'h0, 2'h0}, '{1'b0, 6'h10, 32'hF000, 2'h0, 2'h0},
      '{1'b0, 6'h0C, 32'h0, 2'h0, 2'h0}, '{1'b1, 6'h00, 32'hFFFFFFFF, 2'h2, 2'h0},
      '{1'b0, 6'h24, 32'h0, 2'h2, 2'h0}, '{1'b1, 6'h04, 32'h300, 2'h0, 2'h2},
      '{1'b0, 6'h0C, 32'h300, 2'h0, 2'h2}, '{1'b1, 6'h04, 32'h0, 2'h0, 2'h2},
      '{1'b0, 6'h04, 32'h300, 2'h0, 2'h2}, '{1'b1, 6'h14, 32'h3100, 2'h0, 2'h3},
      '{1'b0, 6'h04, 32'h200, 2'h0, 2'h3}, '{1'b0, 6'h1C, 32'h3001, 2'h0, 2'h3},
      '{1'b0, 6'h0C, 32'h201, 2'h0, 2'h3}, '{1'b1, 6'h04, 32'h1000, 2'h0, 2'h3},
      '{1'b0, 6'h14, 32'h2100, 2'h0, 2'h3}, '{1'b1, 6'h08, 32'h1200, 2'h0, 2'h3},
      '{1'b0, 6'h04, 32'h0, 2'h0, 2'h3}, '{1'b0, 6'h08, 32'h0, 2'h0, 2'h3},
      '{1'b1, 6'h18, 32'h2100, 2'h0, 2'h0}, '{1'b0, 6'h14, 32'h0, 2'h0, 2'h0},
      '{1'b1, 6'h20, 32'h6, 2'h0, 2'h3}, '{1'b0, 6'h10, 32'hF003, 2'h0, 2'h3},
      '{1'b0, 6'h1C, 32'h3, 2'h0, 2'h3}, '{1'b0, 6'h0C, 32'h3, 2'h0, 2'h3},
      '{1'b0, 6'h20, 32'h6, 2'h0, 2'h3}, '{1'b1, 6'h20, 32'hFFFFFFF9, 2'h0, 2'h0},
      '{1'b0, 6'h20, 32'h0, 2'h0, 2'h0}};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    {normal_set, fast_set, err_count, n_compared} = 128'h0;
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    normal_set <= 32'hF00;
    fast_set <= 32'hF000;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 29; i++) begin
      bus(rows[i].wr, rows[i].addr, rows[i].data, q, r);
      repeat (3) @(posedge sys_clk);
      if (!rows[i].wr) check(q, rows[i].data);
      check({30'h0, r}, {30'h0, rows[i].resp});
      check({30'h0, normal_interrupt_request, fast_interrupt_request}, {30'h0, rows[i].irq});
    end
    $display("table test done");
    // Reset while a programmed request and a mask are up
    bus(1'b1, 6'h20, 32'h6, q, r);
    bus(1'b1, 6'h04, 32'hF00, q, r);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check({30'h0, normal_interrupt_request, fast_interrupt_request}, 32'h0);
    bus(1'b0, 6'h20, 32'h0, q, r);
    check(q, 32'h0);
    bus(1'b0, 6'h04, 32'h0, q, r);
    check(q, 32'h0);
    $display("reset test done");
    complete_run();
  end
endmodule
`default_nettype wire
